// >>> dcfg_params.svh
// register offsets, field positions, reset values and timing for the device configuration bank
`ifndef DCFG_PARAMS_SVH
`define DCFG_PARAMS_SVH

`define DCFG_ADDR_W 12
`define DCFG_DEV_CFG_OFFSET 12'h7c8

// writable storage bits and reset image
`define DCFG_WRITE_MASK 32'h07dbfe70
`define DCFG_RESET_VALUE 32'h00089220

`define DCFG_MEM_COUNT_BIT 4
`define DCFG_MEM_ORG_LSB 5
`define DCFG_MEM_ORG_MSB 6
`define DCFG_LOOKUP_AGING_BIT 9
`define DCFG_HASH_SEL_LSB 10
`define DCFG_HASH_SEL_MSB 11
`define DCFG_HASH_SIZE_LSB 12
`define DCFG_HASH_SIZE_MSB 13
`define DCFG_IPM_OFF_BIT 15
`define DCFG_LEARN_OFF_BIT 16
`define DCFG_PARTIAL_SYNC_BIT 17
`define DCFG_FRAME_AGING_BIT 19
`define DCFG_OVERSIZE_FWD_BIT 20
`define DCFG_BUF_DEC_BIT 21
`define DCFG_BUF_CNT_EN_BIT 22
`define DCFG_STAT_EN_BIT 23
`define DCFG_PCS_SEL_BIT 24
`define DCFG_TX_GATE_BIT 25
`define DCFG_MC_PRIV_BIT 26

// wait states inserted on every processor access
`define DCFG_WAIT_CYCLES 2
`define DCFG_CNT_W 4

`endif

// >>> dcfg_pkg.sv
// types for the device configuration bank
package dcfg_pkg;
	typedef enum logic [1:0] {
		DCFG_IDLE = 2'b00,
		DCFG_WAIT = 2'b01,
		DCFG_DONE = 2'b10
	} dcfg_state_t;
endpackage

// >>> dcfg_config.sv
// device configuration register: processor access with wait states and field outputs
`include "dcfg_params.svh"

module dcfg_config
	import dcfg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic host_req,
	input wire logic host_we,
	input wire logic [`DCFG_ADDR_W-1:0] host_addr,
	input wire logic [31:0] host_wdata,
	output logic [31:0] host_rdata,
	output logic host_rdy,
	input wire logic link_up,
	input wire logic mac_tx_en,
	input wire logic mac_tx_led,
	output logic tx_en_out,
	output logic tx_led_out,
	output logic memory_chip_count,
	output logic [1:0] memory_chip_organisation,
	output logic lookup_aging_enable,
	output logic [1:0] hash_bit_selection,
	output logic [1:0] hash_key_size,
	output logic ip_multicast_off,
	output logic learning_off,
	output logic partial_sync,
	output logic frame_aging_enable,
	output logic oversize_forward,
	output logic buffer_count_decrement,
	output logic buffer_count_enable,
	output logic stat_count_enable,
	output logic coding_sublayer_select,
	output logic multicast_privilege
);

	dcfg_state_t state_reg, state_next;
	logic [`DCFG_CNT_W-1:0] cnt_reg, cnt_next;
	logic [31:0] cfg_reg, cfg_next;
	logic [31:0] rdata_reg, rdata_next;
	logic dec_reg, dec_next;
	logic tx_en_reg, tx_en_next;
	logic tx_led_reg, tx_led_next;
	logic addr_hit;

	function automatic logic hits_config(input logic [`DCFG_ADDR_W-1:0] a);
		hits_config = (a == `DCFG_DEV_CFG_OFFSET);
	endfunction

	assign addr_hit = hits_config(host_addr);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		cfg_next = cfg_reg;
		rdata_next = rdata_reg;
		dec_next = 1'b0;
		case (state_reg)
			DCFG_IDLE: begin
				if (host_req) begin
					state_next = DCFG_WAIT;
					cnt_next = '0;
				end
			end
			DCFG_WAIT: begin
				// wait states before the access completes
				if (cnt_reg == `DCFG_CNT_W'(`DCFG_WAIT_CYCLES - 1)) begin
					state_next = DCFG_DONE;
					if (host_we && addr_hit) begin
						cfg_next = host_wdata & `DCFG_WRITE_MASK;
						dec_next = host_wdata[`DCFG_BUF_DEC_BIT];
						rdata_next = '0;
					end else if (!host_we && addr_hit) begin
						rdata_next = cfg_reg;
					end else begin
						// unmapped addresses read zero and drop writes
						rdata_next = '0;
					end
				end else begin
					cnt_next = cnt_reg + `DCFG_CNT_W'(1);
				end
			end
			DCFG_DONE: begin
				// always back to idle so ready cannot stay high two cycles in a row
				state_next = DCFG_IDLE;
			end
			default: begin
				state_next = DCFG_IDLE;
			end
		endcase
		// gating is registered; one cycle behind the mac
		tx_en_next = mac_tx_en & (link_up | cfg_reg[`DCFG_TX_GATE_BIT]);
		tx_led_next = mac_tx_led & (link_up | cfg_reg[`DCFG_TX_GATE_BIT]);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= DCFG_IDLE;
			cnt_reg <= '0;
			cfg_reg <= `DCFG_RESET_VALUE;
			rdata_reg <= '0;
			dec_reg <= 1'b0;
			tx_en_reg <= 1'b0;
			tx_led_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			cfg_reg <= cfg_next;
			rdata_reg <= rdata_next;
			dec_reg <= dec_next;
			tx_en_reg <= tx_en_next;
			tx_led_reg <= tx_led_next;
		end
	end

	assign host_rdy = (state_reg == DCFG_DONE);
	assign host_rdata = rdata_reg;
	assign tx_en_out = tx_en_reg;
	assign tx_led_out = tx_led_reg;
	assign buffer_count_decrement = dec_reg;

	assign memory_chip_count = cfg_reg[`DCFG_MEM_COUNT_BIT];
	assign memory_chip_organisation = cfg_reg[`DCFG_MEM_ORG_MSB:`DCFG_MEM_ORG_LSB];
	assign lookup_aging_enable = cfg_reg[`DCFG_LOOKUP_AGING_BIT];
	assign hash_bit_selection = cfg_reg[`DCFG_HASH_SEL_MSB:`DCFG_HASH_SEL_LSB];
	// key size code 11 is undefined; passed through untouched
	assign hash_key_size = cfg_reg[`DCFG_HASH_SIZE_MSB:`DCFG_HASH_SIZE_LSB];
	assign ip_multicast_off = cfg_reg[`DCFG_IPM_OFF_BIT];
	assign learning_off = cfg_reg[`DCFG_LEARN_OFF_BIT];
	assign partial_sync = cfg_reg[`DCFG_PARTIAL_SYNC_BIT];
	assign frame_aging_enable = cfg_reg[`DCFG_FRAME_AGING_BIT];
	assign oversize_forward = cfg_reg[`DCFG_OVERSIZE_FWD_BIT];
	assign buffer_count_enable = cfg_reg[`DCFG_BUF_CNT_EN_BIT];
	assign stat_count_enable = cfg_reg[`DCFG_STAT_EN_BIT];
	assign coding_sublayer_select = cfg_reg[`DCFG_PCS_SEL_BIT];
	assign multicast_privilege = cfg_reg[`DCFG_MC_PRIV_BIT];

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence s_take;
		state_reg == DCFG_IDLE && host_req;
	endsequence

	sequence s_finish;
		host_rdy ##1 !host_rdy;
	endsequence

	// completed write to the configuration word, as seen on the ready cycle
	sequence s_write_hit;
		host_rdy && host_we && addr_hit;
	endsequence

	// completed write to any other address
	sequence s_write_miss;
		host_rdy && host_we && !addr_hit;
	endsequence

	sequence s_read_miss;
		host_rdy && !host_we && !addr_hit;
	endsequence

	// transmit path held off: gating active and link down
	sequence s_gate_off;
		!cfg_reg[`DCFG_TX_GATE_BIT] && !link_up;
	endsequence

	// taking edge plus two wait edges: ready is low at three sampled edges
	a_ready_after_wait: assert property (s_take |-> !host_rdy [*3] ##1 s_finish)
		else $error("ready not given after the wait states");

	a_write_lands: assert property (
		host_rdy && host_we && addr_hit |-> cfg_reg == (host_wdata & `DCFG_WRITE_MASK))
		else $error("written value not stored");

	a_read_returns: assert property (
		host_rdy && !host_we && addr_hit |-> host_rdata == cfg_reg)
		else $error("read data differs from register");

	a_reserved_zero: assert property ((cfg_reg & ~`DCFG_WRITE_MASK) == 32'h0)
		else $error("reserved bit set");

	a_cfg_only_written: assert property (
		$changed(cfg_reg) |-> host_rdy && host_we && addr_hit)
		else $error("register changed without a write");

	a_dec_single: assert property (buffer_count_decrement |=> !buffer_count_decrement)
		else $error("decrement pulse longer than one cycle");

	a_dec_cause: assert property (
		buffer_count_decrement |-> host_rdy && host_we && addr_hit && host_wdata[`DCFG_BUF_DEC_BIT])
		else $error("decrement without a write of one");

	a_dec_given: assert property (
		host_rdy && host_we && addr_hit && host_wdata[`DCFG_BUF_DEC_BIT] |-> buffer_count_decrement)
		else $error("write of one gave no decrement");

	a_tx_gated: assert property (
		!cfg_reg[`DCFG_TX_GATE_BIT] && !link_up |=> !tx_en_out && !tx_led_out)
		else $error("transmit not gated on link loss");

	a_tx_passes: assert property (
		cfg_reg[`DCFG_TX_GATE_BIT] |=> tx_en_out == $past(mac_tx_en))
		else $error("transmit enable gated while gating is off");

	a_led_passes: assert property (
		cfg_reg[`DCFG_TX_GATE_BIT] |=> tx_led_out == $past(mac_tx_led))
		else $error("transmit led gated while gating is off");

	// with the link up the gate never bites, whatever the bit says
	a_tx_link_up: assert property (
		link_up |=> tx_en_out == $past(mac_tx_en) && tx_led_out == $past(mac_tx_led))
		else $error("transmit gated while the link is up");

	// gating may only remove transmit, never create it
	a_tx_needs_mac: assert property (!mac_tx_en && !mac_tx_led |=> !tx_en_out && !tx_led_out)
		else $error("transmit raised without the mac");

	a_gate_named: assert property (s_gate_off |=> !tx_en_out)
		else $error("transmit enable passed during link loss");

	// the register leaves reset with its documented image
	a_reset_image: assert property (
		$rose(rst_n) |-> cfg_reg == `DCFG_RESET_VALUE)
		else $error("register not at reset image after reset");

	a_reset_quiet: assert property (
		$rose(rst_n) |-> !host_rdy && !buffer_count_decrement && host_rdata == 32'h0)
		else $error("bus outputs not quiet after reset");

	a_take_starts: assert property (s_take |=> state_reg == DCFG_WAIT && cnt_reg == '0)
		else $error("request not taken into the wait state");

	a_wait_bounded: assert property (
		state_reg == DCFG_WAIT |-> cnt_reg < `DCFG_CNT_W'(`DCFG_WAIT_CYCLES))
		else $error("wait counter ran past the wait states");

	// a held request must pass through idle before it is taken again
	a_done_to_idle: assert property (state_reg == DCFG_DONE |=> state_reg == DCFG_IDLE)
		else $error("ready state not followed by idle");

	a_state_legal: assert property (
		state_reg == DCFG_IDLE || state_reg == DCFG_WAIT || state_reg == DCFG_DONE)
		else $error("state register holds an unused code");

	// read data stays put between completions
	a_rdata_held: assert property ($changed(host_rdata) |-> host_rdy)
		else $error("read data changed outside a completion");

	a_miss_read_zero: assert property (s_read_miss |-> host_rdata == 32'h0)
		else $error("unmapped read returned data");

	a_miss_write_drop: assert property (s_write_miss |-> $stable(cfg_reg))
		else $error("unmapped write reached the register");

	a_dec_not_read: assert property (
		host_rdy && !host_we |-> !buffer_count_decrement)
		else $error("decrement given on a read");

	// field outputs are levels; they move only on a completed write
	a_chip_fields_held: assert property (
		$changed({memory_chip_count, memory_chip_organisation}) |-> s_write_hit)
		else $error("memory fields changed without a write");

	a_lookup_fields_held: assert property (
		$changed({lookup_aging_enable, hash_bit_selection, hash_key_size,
			ip_multicast_off, learning_off, partial_sync}) |-> s_write_hit)
		else $error("lookup fields changed without a write");

	a_frame_fields_held: assert property (
		$changed({frame_aging_enable, oversize_forward, buffer_count_enable,
			stat_count_enable, coding_sublayer_select, multicast_privilege}) |-> s_write_hit)
		else $error("frame fields changed without a write");

	// learning stop must reach its output on the write that sets it
	a_learn_follows: assert property (
		s_write_hit |-> learning_off == host_wdata[`DCFG_LEARN_OFF_BIT])
		else $error("learning control not taken from the write");

	a_ipm_follows: assert property (
		s_write_hit |-> ip_multicast_off == host_wdata[`DCFG_IPM_OFF_BIT])
		else $error("ip multicast control not taken from the write");

	a_pcs_follows: assert property (
		s_write_hit |-> coding_sublayer_select == host_wdata[`DCFG_PCS_SEL_BIT])
		else $error("coding sublayer select not taken from the write");

	a_priv_follows: assert property (
		s_write_hit |-> multicast_privilege == host_wdata[`DCFG_MC_PRIV_BIT])
		else $error("multicast privilege not taken from the write");

	a_count_en_follows: assert property (
		s_write_hit |-> buffer_count_enable == host_wdata[`DCFG_BUF_CNT_EN_BIT])
		else $error("buffer counter enable not taken from the write");

	a_stat_en_follows: assert property (
		s_write_hit |-> stat_count_enable == host_wdata[`DCFG_STAT_EN_BIT])
		else $error("status counter enable not taken from the write");

	a_oversize_follows: assert property (
		s_write_hit |-> oversize_forward == host_wdata[`DCFG_OVERSIZE_FWD_BIT])
		else $error("oversize forward not taken from the write");

	a_sync_follows: assert property (
		s_write_hit |-> partial_sync == host_wdata[`DCFG_PARTIAL_SYNC_BIT])
		else $error("partial synchronisation not taken from the write");

	a_hash_follows: assert property (
		s_write_hit |-> hash_key_size == host_wdata[`DCFG_HASH_SIZE_MSB:`DCFG_HASH_SIZE_LSB]
			&& hash_bit_selection == host_wdata[`DCFG_HASH_SEL_MSB:`DCFG_HASH_SEL_LSB])
		else $error("hash fields not taken from the write");

	a_org_follows: assert property (
		s_write_hit |-> memory_chip_organisation == host_wdata[`DCFG_MEM_ORG_MSB:`DCFG_MEM_ORG_LSB])
		else $error("chip organisation not taken from the write");

endmodule // dcfg_config

// >>> test_switch_device_config_fields.sv
// self-checking bench for the device configuration register bank
`include "dcfg_params.svh"

module test_switch_device_config_fields;
	timeunit 1ns;
	timeprecision 1ps;
	// bit 14 belongs to a neighbouring field and is left out of every expectation except the unmapped read
	localparam logic [31:0] FIELD_MASK = 32'h07dbbe70;
	localparam logic [31:0] OUT_MASK = 32'h05dbbe70;
	localparam logic [11:0] REG_ADDR = `DCFG_DEV_CFG_OFFSET;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic host_req = 1'b0;
	logic host_we = 1'b0;
	logic [11:0] host_addr = 12'h000;
	logic [31:0] host_wdata = 32'h0, host_rdata, rd;
	logic link_up = 1'b0, mac_tx_en = 1'b0, mac_tx_led = 1'b0;
	logic host_rdy, tx_en_out, tx_led_out, memory_chip_count, lookup_aging_enable;
	logic ip_multicast_off, learning_off, partial_sync, frame_aging_enable, oversize_forward;
	logic buffer_count_decrement, buffer_count_enable, stat_count_enable;
	logic coding_sublayer_select, multicast_privilege;
	logic [1:0] memory_chip_organisation, hash_bit_selection, hash_key_size;
	int mismatches = 0, samples_checked = 0, dec_pulses = 0, n, d0;
	logic [31:0] pat [4] = '{32'hffffffff, 32'h0, 32'h55555555, 32'haaaaaaaa};

	dcfg_config i_dut (.*);

	initial begin
		forever #2 clk_sys = ~clk_sys;
	end

	// counted on the falling edge so the pulse is settled
	always @(negedge clk_sys) begin
		if (buffer_count_decrement === 1'b1)
			dec_pulses++;
	end

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic access(input logic we, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rdo);
		@(posedge clk_sys);
		host_req <= 1'b1;
		host_we <= we;
		host_addr <= a;
		host_wdata <= wd;
		n = 0;
		@(posedge clk_sys);
		while (host_rdy !== 1'b1 && n < 16) begin
			@(posedge clk_sys);
			n++;
		end
		rdo = host_rdata;
		host_req <= 1'b0;
		check_word({31'h0, n < 16}, 32'h1, "ready in time");
		@(posedge clk_sys);
		check_word({31'h0, host_rdy}, 32'h0, "ready one cycle");
	endtask

	function automatic logic [31:0] fields();
		return {5'h0, multicast_privilege, 1'b0, coding_sublayer_select, stat_count_enable,
			buffer_count_enable, 1'b0, oversize_forward, frame_aging_enable, 1'b0,
			partial_sync, learning_off, ip_multicast_off, 1'b0, hash_key_size,
			hash_bit_selection, lookup_aging_enable, 2'b0, memory_chip_organisation,
			memory_chip_count, 4'h0};
	endfunction

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk_sys);
		check_word(fields(), `DCFG_RESET_VALUE & OUT_MASK, "reset outputs");
		rst_n <= 1'b1;
		access(1'b0, REG_ADDR, 32'h0, rd);
		check_word(rd & ~32'h4000, `DCFG_RESET_VALUE & FIELD_MASK, "reset read");
		$display("test reset done");
		foreach (pat[i]) begin
			d0 = dec_pulses;
			access(1'b1, REG_ADDR, pat[i], rd);
			check_word(32'(dec_pulses - d0), {31'h0, pat[i][21]}, "decrement");
			check_word(fields(), pat[i] & OUT_MASK, "outputs");
			access(1'b0, REG_ADDR, 32'h0, rd);
			check_word(rd & ~32'h4000, pat[i] & FIELD_MASK, "readback");
		end
		$display("test patterns done");
		for (int g = 0; g < 2; g++) begin
			access(1'b1, REG_ADDR, 32'(g) << 25, rd);
			for (int l = 0; l < 2; l++) begin
				link_up <= l[0];
				mac_tx_en <= 1'b1;
				mac_tx_led <= ~l[0];
				repeat (2) @(posedge clk_sys);
				check_word({30'h0, tx_en_out, tx_led_out},
					{30'h0, l[0] | g[0], ~l[0] & g[0]}, "tx gating");
			end
		end
		$display("test gating done");
		access(1'b1, REG_ADDR + 12'h4, 32'hffffffff, rd);
		access(1'b0, REG_ADDR + 12'h4, 32'h0, rd);
		check_word(rd, 32'h0, "unmapped read");
		access(1'b0, REG_ADDR, 32'h0, rd);
		check_word(rd & ~32'h4000, 32'h1 << 25, "register kept");
		$display("test unmapped done");
		stop_test();
	end

	// whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		mismatches++;
		stop_test();
	end
endmodule // test_switch_device_config_fields
